// File: design/otp_programming_mode_pkg.sv
// constants and types shared by the otp programming buffer files
package otp_programming_mode_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register byte addresses
    localparam logic [31:0] MODE_OFFSET = 32'h07F40000;
    localparam logic [31:0] STATUS_OFFSET = 32'h07F40004;
    localparam logic [31:0] ADDRESS_OFFSET = 32'h07F40008;
    localparam logic [31:0] DATA_OFFSET = 32'h07F4000C;
    localparam logic [31:0] IRQ_STATUS_OFFSET = 32'h07F40040;
    localparam logic [31:0] IRQ_MASK_OFFSET = 32'h07F40044;

    ////////////////////////////////////////////////////////////////////////
    // field layout and reset values
    localparam int WORD_ADDR_WIDTH = 13;
    localparam int MODE_WIDTH = 3;
    localparam int IRQ_WIDTH = 3;
    localparam int STAT_IDLE_BIT = 0;
    localparam int STAT_EMPTY_BIT = 1;
    localparam int STAT_MODE_DONE_BIT = 2;
    localparam int IRQ_MODE_DONE_BIT = 0;
    localparam int IRQ_ACCEPT_BIT = 1;
    localparam int IRQ_PROGRAMMING_MODE_DONE_BIT = 2;
    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam logic [2:0] MODE_PROGRAM = 3'h3;
    localparam logic [12:0] ADDRESS_RESET = 13'h0000;
    localparam logic [31:0] DATA_RESET = 32'h00000000;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
    localparam logic [31:0] READ_ZERO = 32'h00000000;

    ////////////////////////////////////////////////////////////////////////
    // timing, least times rounded up to whole cycles
    localparam int CLOCK_PERIOD_NS = 50;
    localparam int PROGRAMMING_MODE_PULSE_NS = 10000;
    localparam int MODE_SETTLE_NS = 10000;
    localparam int PROGRAMMING_MODE_PULSE_CYCLES =
        (PROGRAMMING_MODE_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int MODE_SETTLE_CYCLES =
        (MODE_SETTLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic [12:0] addr;
        logic [31:0] data;
    } programming_mode_request_type;

    typedef struct packed {
        logic programming_mode_enable;
        logic [12:0] addr;
        logic [31:0] data;
    } otp_pins_type;

endpackage

// File: design/otp_mode_tracker.sv
// controller mode field and its transition-done flag
`timescale 1ns/1ps
module otp_mode_tracker #(
    parameter int SETTLE_CYCLES = otp_programming_mode_pkg::MODE_SETTLE_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_write,
    input wire logic [2:0] i_mode,
    output logic [2:0] o_mode,
    output logic o_done,
    output logic o_done_pulse
);
    localparam int CW = $clog2(SETTLE_CYCLES + 1);

    logic [2:0] mode_reg, mode_next;
    logic done_reg, done_next;
    logic pulse_reg, pulse_next;
    logic [CW-1:0] count_reg, count_next;

    always_comb begin
        mode_next = mode_reg;
        done_next = done_reg;
        pulse_next = 1'b0;
        count_next = count_reg;
        // mode field is frozen while a transition runs
        if (done_reg && i_write && i_mode != mode_reg) begin
            mode_next = i_mode;
            done_next = 1'b0;
            count_next = CW'(SETTLE_CYCLES - 1);
        end else if (!done_reg) begin
            if (count_reg == '0) begin
                done_next = 1'b1;
                pulse_next = 1'b1;
            end else begin
                count_next = count_reg - 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            mode_reg <= otp_programming_mode_pkg::MODE_RESET;
            done_reg <= 1'b1;
            pulse_reg <= 1'b0;
            count_reg <= '0;
        end else begin
            mode_reg <= mode_next;
            done_reg <= done_next;
            pulse_reg <= pulse_next;
            count_reg <= count_next;
        end
    end

    assign o_mode = mode_reg;
    assign o_done = done_reg;
    assign o_done_pulse = pulse_reg;
endmodule

// File: design/otp_array_writer.sv
// takes one buffered request and drives the array programming pins
`timescale 1ns/1ps
module otp_array_writer #(
    parameter int PULSE_CYCLES = otp_programming_mode_pkg::PROGRAMMING_MODE_PULSE_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_request_valid,
    input wire otp_programming_mode_pkg::programming_mode_request_type i_request,
    output logic o_accept,
    output logic o_busy,
    output logic o_done_pulse,
    output otp_programming_mode_pkg::otp_pins_type o_pins
);
    localparam int CW = $clog2(PULSE_CYCLES + 1);

    typedef enum logic {IDLE, PULSE} writer_state_type;

    writer_state_type state_reg, state_next;
    logic [CW-1:0] count_reg, count_next;
    logic done_reg, done_next;
    otp_programming_mode_pkg::otp_pins_type pins_reg, pins_next;

    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        done_next = 1'b0;
        pins_next = pins_reg;
        case (state_reg)
            IDLE: begin
                if (i_request_valid) begin
                    state_next = PULSE;
                    count_next = CW'(PULSE_CYCLES - 1);
                    pins_next.programming_mode_enable = 1'b1;
                    pins_next.addr = i_request.addr;
                    pins_next.data = i_request.data;
                end
            end
            PULSE: begin
                if (count_reg == '0) begin
                    state_next = IDLE;
                    done_next = 1'b1;
                    pins_next.programming_mode_enable = 1'b0;
                end else begin
                    count_next = count_reg - 1'b1;
                end
            end
            default: begin
                state_next = IDLE;
                pins_next.programming_mode_enable = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            state_reg <= IDLE;
            count_reg <= '0;
            done_reg <= 1'b0;
            pins_reg <= '0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            done_reg <= done_next;
            pins_reg <= pins_next;
        end
    end

    assign o_accept = i_request_valid && state_reg == IDLE;
    assign o_busy = state_reg != IDLE;
    assign o_done_pulse = done_reg;
    assign o_pins = pins_reg;
endmodule

// File: design/otp_program_buffer_status.sv
// otp programming buffer, status register and avalon-mm register slave
//
// Contract
// - Mode-ready goes to 1 once a newly selected mode has settled.
// - Buffer-empty 0 means a request is held; software keeps off it.
// - Buffer-empty reads 1 when nothing is pending and resets to 1.
// - An address write that triggers programming clears buffer-empty.
// - Programming-idle reads 0 while programming runs, else 1.
// - The address register holds 13 bits; bits 31:13 read zero.
// - Address and data writes are ignored while buffer-empty is 0.
// - An address write starts programming only in programming mode.
// - Address and data form a one-entry request buffer to the array.
// - Mode value 3 of the three-bit mode field is programming mode.
`timescale 1ns/1ps
module otp_program_buffer_status #(
    parameter int PROGRAMMING_MODE_PULSE_CYCLES = otp_programming_mode_pkg::PROGRAMMING_MODE_PULSE_CYCLES,
    parameter int MODE_SETTLE_CYCLES = otp_programming_mode_pkg::MODE_SETTLE_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic [31:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic o_irq,
    output logic [2:0] o_otp_mode,
    output otp_programming_mode_pkg::otp_pins_type o_otp_pins
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_value,
        input logic [31:0] new_value,
        input logic [3:0] enables
    );
        logic [31:0] result;
        result = old_value;
        for (int i = 0; i < 4; i++) begin
            if (enables[i]) begin
                result[i*8 +: 8] = new_value[i*8 +: 8];
            end
        end
        return result;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic wait_reg, wait_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [12:0] addr_reg, addr_next;
    logic [31:0] data_reg, data_next;
    logic pending_reg, pending_next;
    logic [2:0] mask_reg, mask_next;
    logic [2:0] irq_status_reg, irq_status_next;
    logic irq_reg, irq_next;

    logic request;
    logic fire_write;
    logic mode_write;
    logic [2:0] mode_wdata;
    logic [2:0] mode;
    logic mode_done;
    logic mode_done_pulse;
    logic programming_mode_active;
    logic accept;
    logic busy;
    logic programming_mode_done_pulse;
    logic [2:0] events;
    logic [2:0] irq_clear;
    logic [31:0] status_word;
    logic [31:0] merged;
    logic [31:0] mode_merged, addr_merged, mask_merged;
    otp_programming_mode_pkg::programming_mode_request_type held_request;

    ////////////////////////////////////////////////////////////////////////
    // sub-blocks

    otp_mode_tracker #(
        .SETTLE_CYCLES(MODE_SETTLE_CYCLES)
    ) u_mode (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_write(mode_write),
        .i_mode(mode_wdata),
        .o_mode(mode),
        .o_done(mode_done),
        .o_done_pulse(mode_done_pulse)
    );

    assign held_request.addr = addr_reg;
    assign held_request.data = data_reg;

    otp_array_writer #(
        .PULSE_CYCLES(PROGRAMMING_MODE_PULSE_CYCLES)
    ) u_writer (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_request_valid(pending_reg),
        .i_request(held_request),
        .o_accept(accept),
        .o_busy(busy),
        .o_done_pulse(programming_mode_done_pulse),
        .o_pins(o_otp_pins)
    );

    ////////////////////////////////////////////////////////////////////////
    // decode and status

    assign request = i_avs_read || i_avs_write;
    // a write lands only on the edge where waitrequest is seen low
    assign fire_write = i_avs_write && !wait_reg;
    assign merged = merge_bytes(32'h00000000, i_avs_writedata,
        i_avs_byteenable);
    assign mode_write = fire_write &&
        i_avs_address == otp_programming_mode_pkg::MODE_OFFSET;
    assign mode_merged = merge_bytes({29'h00000000, mode}, i_avs_writedata,
        i_avs_byteenable);
    assign mode_wdata = mode_merged[2:0];
    assign addr_merged = merge_bytes({19'h00000, addr_reg}, i_avs_writedata,
        i_avs_byteenable);
    assign mask_merged = merge_bytes({29'h00000000, mask_reg},
        i_avs_writedata, i_avs_byteenable);
    // no launch while the mode is still settling
    assign programming_mode_active = mode == otp_programming_mode_pkg::MODE_PROGRAM
        && mode_done;
    assign status_word = {29'h00000000, mode_done, !pending_reg,
        !busy};
    assign events = {programming_mode_done_pulse, accept, mode_done_pulse};
    assign irq_clear = (fire_write &&
        i_avs_address == otp_programming_mode_pkg::IRQ_STATUS_OFFSET) ?
        merged[2:0] : 3'h0;

    ////////////////////////////////////////////////////////////////////////
    // bus handshake: one wait cycle, read data captured meanwhile

    always_comb begin
        wait_next = !(request && wait_reg);
        rdata_next = rdata_reg;
        if (i_avs_read && wait_reg) begin
            case (i_avs_address)
                otp_programming_mode_pkg::MODE_OFFSET:
                    rdata_next = {29'h00000000, mode};
                otp_programming_mode_pkg::STATUS_OFFSET:
                    rdata_next = status_word;
                otp_programming_mode_pkg::ADDRESS_OFFSET:
                    rdata_next = {19'h00000, addr_reg};
                otp_programming_mode_pkg::DATA_OFFSET:
                    rdata_next = data_reg;
                otp_programming_mode_pkg::IRQ_STATUS_OFFSET:
                    rdata_next = {29'h00000000, irq_status_reg};
                otp_programming_mode_pkg::IRQ_MASK_OFFSET:
                    rdata_next = {29'h00000000, mask_reg};
                default:
                    rdata_next = otp_programming_mode_pkg::READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            wait_reg <= 1'b1;
            rdata_reg <= 32'h00000000;
        end else begin
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // request buffer and interrupt registers

    always_comb begin
        addr_next = addr_reg;
        data_next = data_reg;
        pending_next = pending_reg;
        mask_next = mask_reg;
        // set wins over a write-one clear in the same cycle
        irq_status_next = (irq_status_reg & ~irq_clear) | events;
        if (accept) begin
            pending_next = 1'b0;
        end
        // while a request is held both buffer words are read-only
        if (fire_write && !pending_reg) begin
            if (i_avs_address == otp_programming_mode_pkg::ADDRESS_OFFSET) begin
                addr_next = addr_merged[12:0];
                if (programming_mode_active) begin
                    pending_next = 1'b1;
                end
            end
            if (i_avs_address == otp_programming_mode_pkg::DATA_OFFSET) begin
                data_next = merge_bytes(data_reg, i_avs_writedata,
                    i_avs_byteenable);
            end
        end
        if (fire_write && i_avs_address == otp_programming_mode_pkg::IRQ_MASK_OFFSET)
        begin
            mask_next = mask_merged[2:0];
        end
        irq_next = |(irq_status_next & mask_next);
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            addr_reg <= otp_programming_mode_pkg::ADDRESS_RESET;
            data_reg <= otp_programming_mode_pkg::DATA_RESET;
            pending_reg <= 1'b0;
            mask_reg <= otp_programming_mode_pkg::IRQ_MASK_RESET;
            irq_status_reg <= 3'h0;
            irq_reg <= 1'b0;
        end else begin
            addr_reg <= addr_next;
            data_reg <= data_next;
            pending_reg <= pending_next;
            mask_reg <= mask_next;
            irq_status_reg <= irq_status_next;
            irq_reg <= irq_next;
        end
    end

    assign o_avs_readdata = rdata_reg;
    assign o_avs_waitrequest = wait_reg;
    assign o_irq = irq_reg;
    assign o_otp_mode = mode;

    ////////////////////////////////////////////////////////////////////////
    // checks

    localparam int MODE_WAIT_MAX = 1000;

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_srst);

    logic mode_change;
    assign mode_change = mode_write && mode_done && mode_wdata != mode;

    property p_mode_ready;
        mode_change |=> !mode_done ##[1:MODE_WAIT_MAX] mode_done;
    endproperty
    a_mode_ready: assert property (p_mode_ready)
        else $error("mode ready did not follow a mode change");

    // a status read must show the buffer and writer state it was taken in
    property p_empty_bit;
        i_avs_read && wait_reg && i_avs_address == otp_programming_mode_pkg::STATUS_OFFSET
            |=> o_avs_readdata[1] == !$past(pending_reg)
            && o_avs_readdata[0] == !$past(busy);
    endproperty
    a_empty_bit: assert property (p_empty_bit)
        else $error("empty bit disagrees with buffer state");

    property p_trigger_clears_empty;
        fire_write && i_avs_address == otp_programming_mode_pkg::ADDRESS_OFFSET
            && !pending_reg && programming_mode_active |=> pending_reg && !status_word[1];
    endproperty
    a_trigger_clears_empty: assert property (p_trigger_clears_empty)
        else $error("trigger did not mark buffer full");

    property p_held_stable;
        pending_reg && $past(pending_reg) |-> $stable(addr_reg)
            && $stable(data_reg);
    endproperty
    a_held_stable: assert property (p_held_stable)
        else $error("held request changed");

    property p_write_ignored;
        fire_write && pending_reg |=> $stable(data_reg) && $stable(addr_reg);
    endproperty
    a_write_ignored: assert property (p_write_ignored)
        else $error("buffer written while full");

    property p_addr_upper_zero;
        i_avs_read && wait_reg
            && i_avs_address == otp_programming_mode_pkg::ADDRESS_OFFSET
            |=> o_avs_readdata[31:13] == 19'h00000;
    endproperty
    a_addr_upper_zero: assert property (p_addr_upper_zero)
        else $error("address upper bits not zero");

    property p_launch_only_programming_mode;
        fire_write && i_avs_address == otp_programming_mode_pkg::ADDRESS_OFFSET
            && !pending_reg && !programming_mode_active |=> !pending_reg;
    endproperty
    a_launch_only_programming_mode: assert property (p_launch_only_programming_mode)
        else $error("programming launched outside programming mode");

    property p_accept;
        pending_reg && !busy |=> !pending_reg && busy
            && o_otp_pins.addr == $past(addr_reg)
            && o_otp_pins.data == $past(data_reg);
    endproperty
    a_accept: assert property (p_accept)
        else $error("request not taken into the array writer");

    property p_idle_low_pulse;
        $rose(busy) |-> !status_word[0] [*8];
    endproperty
    a_idle_low_pulse: assert property (p_idle_low_pulse)
        else $error("idle bit rose during programming");

    property p_programming_mode_mode_value;
        $rose(pending_reg) |-> $past(mode) == otp_programming_mode_pkg::MODE_PROGRAM
            && $past(mode_done);
    endproperty
    a_programming_mode_mode_value: assert property (p_programming_mode_mode_value)
        else $error("programming active in wrong mode");

    property p_cov_program;
        accept ##[1:MODE_WAIT_MAX] programming_mode_done_pulse;
    endproperty
    c_cov_program: cover property (p_cov_program);

    property p_cov_mode;
        mode_change ##1 !mode_done;
    endproperty
    c_cov_mode: cover property (p_cov_mode);

    property p_cov_refused;
        fire_write && pending_reg;
    endproperty
    c_cov_refused: cover property (p_cov_refused);

    property p_cov_irq;
        $rose(o_irq);
    endproperty
    c_cov_irq: cover property (p_cov_irq);

endmodule

// File: test/otp_array_model.sv
// behavioural model of the otp array macro behind the programming pins
`timescale 1ns/1ps
module otp_array_model (
    input wire logic i_clock,
    input wire otp_programming_mode_pkg::otp_pins_type i_pins,
    output logic [44:0] o_word,
    output logic o_strobe,
    output int o_len
);
    logic on_reg = 1'b0;
    logic moved_reg = 1'b0;
    int len_reg = 0;
    logic [44:0] word_reg = 45'h0;

    ////////////////////////////////////////////////////////////////////////
    // one cell write per pulse; address and data must stand for all of it
    always @(posedge i_clock) begin
        o_strobe <= 1'b0;
        on_reg <= (i_pins.programming_mode_enable === 1'b1);
        if (i_pins.programming_mode_enable === 1'b1) begin
            len_reg <= len_reg + 1;
            if (!on_reg) begin
                word_reg <= {i_pins.addr, i_pins.data};
                moved_reg <= 1'b0;
            end else if ({i_pins.addr, i_pins.data} !== word_reg) begin
                moved_reg <= 1'b1;
            end
        end else if (on_reg) begin
            // a word that moved mid pulse is reported corrupted
            o_word <= moved_reg ? ~word_reg : word_reg;
            o_len <= len_reg;
            o_strobe <= 1'b1;
            len_reg <= 0;
        end
    end
endmodule

// File: test/otp_program_buffer_status_test.sv
// self-checking bench for the otp programming buffer and status block
`timescale 1ns/1ps
`define CHECK(got, exp) begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
        fails++; \
        $display("BAD t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
end
module otp_program_buffer_status_test;
    localparam int PULSE = 20;
    localparam int SETTLE = 8;
    localparam logic [31:0] MODE = otp_programming_mode_pkg::MODE_OFFSET;
    localparam logic [31:0] STAT = otp_programming_mode_pkg::STATUS_OFFSET;
    localparam logic [31:0] ADDR = otp_programming_mode_pkg::ADDRESS_OFFSET;
    localparam logic [31:0] DATA = otp_programming_mode_pkg::DATA_OFFSET;
    localparam logic [31:0] IRQS = otp_programming_mode_pkg::IRQ_STATUS_OFFSET;
    localparam logic [31:0] IRQM = otp_programming_mode_pkg::IRQ_MASK_OFFSET;
    logic i_clock = 1'b0;
    logic i_srst = 1'b1;
    logic [31:0] avs_address = 32'h00000000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] readdata;
    logic waitrequest;
    logic irq;
    logic [2:0] otp_mode;
    otp_programming_mode_pkg::otp_pins_type pins;
    logic [44:0] seen_word;
    logic seen_strobe;
    int seen_len;
    int fails = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [44:0] exp_q[$];
    logic [31:0] rd;
    logic [31:0] d1;
    logic [31:0] d2;
    logic [12:0] a1;
    logic [12:0] a2;

    always #25 i_clock = ~i_clock;

    otp_program_buffer_status #(
        .PROGRAMMING_MODE_PULSE_CYCLES(PULSE),
        .MODE_SETTLE_CYCLES(SETTLE)
    ) dut (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_avs_address(avs_address),
        .i_avs_read(avs_read),
        .i_avs_write(avs_write),
        .i_avs_writedata(avs_writedata),
        .i_avs_byteenable(avs_byteenable),
        .o_avs_readdata(readdata),
        .o_avs_waitrequest(waitrequest),
        .o_irq(irq),
        .o_otp_mode(otp_mode),
        .o_otp_pins(pins)
    );

    otp_array_model array (
        .i_clock(i_clock),
        .i_pins(pins),
        .o_word(seen_word),
        .o_strobe(seen_strobe),
        .o_len(seen_len)
    );

    ////////////////////////////////////////////////////////////////////////
    // bus access: held until waitrequest is sampled low, then released
    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge i_clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge i_clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50) fails++;
        rd = readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask

    task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h00000000, 4'hF);
        `CHECK(rd, e)
    endtask

    // polls status until the masked bits match, under a bounded count
    task automatic wait_status(input logic [31:0] m, input logic [31:0] v);
        int n;
        n = 0;
        do begin
            bus(1'b0, STAT, 32'h00000000, 4'hF);
            n++;
        end while ((rd & m) !== v && n < 100);
        `CHECK(rd & m, v)
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // every finished array write is matched against the expected queue
    always @(posedge i_clock) begin
        cycles++;
        if (cycles >= 20000) begin
            fails++;
            summarize();
        end else if (seen_strobe === 1'b1) begin
            `CHECK(seen_word, exp_q.pop_front())
            `CHECK(seen_len, PULSE)
        end
    end

    initial begin
        void'($urandom(32'hDAA0));
        repeat (2) @(posedge i_clock);
        i_srst <= 1'b0;
        rdchk(STAT, 32'h00000007);
        rdchk(ADDR, 32'h00000000);
        rdchk(DATA, 32'h00000000);
        rdchk(32'h07F40020, 32'h00000000);
        $display("test reset done");
        // outside programming mode an address write only stores
        d1 = $urandom();
        d2 = $urandom();
        wr(DATA, d1);
        wr(ADDR, d2);
        rdchk(STAT, 32'h00000007);
        rdchk(ADDR, {19'h0, d2[12:0]});
        bus(1'b1, DATA, 32'hFFFFFFFF, 4'h3);
        rdchk(DATA, {d1[31:16], 16'hFFFF});
        wr(STAT, 32'h00000000);
        rdchk(STAT, 32'h00000007);
        $display("test store only done");
        wr(MODE, 32'h00000003);
        rdchk(STAT, 32'h00000003);
        wait_status(32'h00000004, 32'h00000004);
        `CHECK(otp_mode, 3'h3)
        rdchk(IRQS, 32'h00000001);
        `CHECK(irq, 1'b0)
        wr(IRQM, 32'h00000001);
        repeat (2) @(posedge i_clock);
        `CHECK(irq, 1'b1)
        wr(IRQS, 32'h00000001);
        repeat (2) @(posedge i_clock);
        `CHECK(irq, 1'b0)
        wr(IRQS, 32'h00000007);
        wr(IRQM, 32'h00000000);
        $display("test mode and irq done");
        for (int k = 0; k < 3; k++) begin
            d1 = $urandom();
            a1 = 13'($urandom());
            wr(DATA, d1);
            exp_q.push_back({a1, d1});
            wr(ADDR, {19'h0, a1});
            rdchk(STAT, 32'h00000006);
            wait_status(32'h00000001, 32'h00000001);
        end
        $display("test programming done");
        // second request waits while the first pulse runs
        d1 = $urandom();
        d2 = $urandom();
        a1 = 13'($urandom());
        a2 = 13'h1FFF;
        wr(DATA, d1);
        exp_q.push_back({a1, d1});
        wr(ADDR, {19'h0, a1});
        wr(DATA, d2);
        exp_q.push_back({a2, d2});
        wr(ADDR, {19'h0, a2});
        rdchk(STAT, 32'h00000004);
        wr(DATA, ~d2);
        wr(ADDR, 32'h00000000);
        rdchk(DATA, d2);
        rdchk(ADDR, {19'h0, a2});
        wait_status(32'h00000003, 32'h00000003);
        rdchk(IRQS, 32'h00000006);
        `CHECK(exp_q.size(), 0)
        $display("test pending request done");
        summarize();
    end
endmodule
